// File: verilog/two_wire_pkg.sv
// Constants, register map, status codes and sequencer states of the two-wire master receiver
// Overview of operation
// - Control write with flag, start and enable set starts a START once the bus is free.
// - After a START goes out, the flag is set and status shows 0x08.
// - Address direction bit selects master receive (read) or master transmit (write).
// - After the read address and its acknowledge, the flag is set with 0x38, 0x40 or 0x48.
// - Writing one to the flag clears it and lets the bus operation continue.
// - Each received byte is in the data register when the flag is set.
// - Control write with flag, stop and enable set generates a STOP.
// - Start request while holding the bus gives a repeated START and status 0x10.
// - In 0x08 or 0x10 a loaded address is sent; a write address enters transmit mode.
// - In 0x38 the bus is released; with start set a START follows when bus is free.
// - In 0x40 or 0x50 the next byte is received and acked per ack enable.
// - In 0x48 start and stop choose repeated START, STOP or STOP then START.
// - In 0x58 start and stop choose repeated START, STOP or STOP then START.
// - The device clears the stop request bit itself once the STOP is generated.
package two_wire_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int TMR_W = 16;

  // Register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h010;

  // Control register bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WC = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_STEP = 0;
  localparam int IRQ_LOST = 1;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Status codes, prescaler bits already zero
  localparam logic [7:0] ST_START_SENT = 8'h08;
  localparam logic [7:0] ST_RSTART_SENT = 8'h10;
  localparam logic [7:0] ST_WADDR_ACK = 8'h18;
  localparam logic [7:0] ST_WADDR_NACK = 8'h20;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_RADDR_ACK = 8'h40;
  localparam logic [7:0] ST_RADDR_NACK = 8'h48;
  localparam logic [7:0] ST_BYTE_ACK = 8'h50;
  localparam logic [7:0] ST_BYTE_NACK = 8'h58;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] STATUS_CODE_MASK = 8'hF8;

  // Quarter phases of one bit slot
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Sequencer states, Gray coded in declaration order
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_START = 3'b001,
    SEQ_ADDR  = 3'b011,
    SEQ_AACK  = 3'b010,
    SEQ_HOLD  = 3'b110,
    SEQ_RX    = 3'b111,
    SEQ_ACK   = 3'b101,
    SEQ_STOP  = 3'b100
  } seq_state_e;

endpackage

// File: verilog/line_sync.sv
// Two-flop synchroniser for the serial bus line inputs
`timescale 1ns/1ps
module line_sync #(
  parameter int width = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);

  logic [width-1:0] meta;

  // Idle bus lines are high, so both stages reset to one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// File: verilog/two_wire_master_receiver.sv
// Two-wire bus master receiver with APB register file and interrupt
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module two_wire_master_receiver
  import two_wire_pkg::*;
#(
  parameter int quarter_cycles = QUARTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(quarter_cycles - 1);

  logic [1:0] lines_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic busy;
  logic next_busy;

  seq_state_e st, next_st;
  logic [1:0] phase, next_phase;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic next_scl_oe, next_sda_oe;
  logic own_bus, next_own_bus;
  logic rx_mode, next_rx_mode;
  logic ack_bit, next_ack_bit;
  logic flag, next_flag;
  logic ack_en, next_ack_en;
  logic sta, next_sta;
  logic sto, next_sto;
  logic wc, next_wc;
  logic en, next_en;
  logic ie, next_ie;
  logic [7:0] status, next_status;
  logic [7:0] data, next_data;
  logic [IRQ_W-1:0] irq_sts, next_irq_sts;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;

  logic q_end;
  logic set_flag;
  logic lost;
  logic wr_hit;
  logic rd_phase;
  logic [31:0] rd_word;
  logic mapped;

  // Both line inputs cross into the pclk domain before any logic looks at them
  line_sync #(
    .width(2)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({scl_in, sda_in}),
    .dout(lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  // Bus free detector: START while clock high makes it busy, STOP frees it
  always_comb begin
    next_busy = busy;
    if (scl_s && scl_d && sda_d && !sda_s) begin
      next_busy = 1'b1;
    end
    if (scl_s && scl_d && !sda_d && sda_s) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      busy <= next_busy;
    end
  end

  // APB access phase qualifiers; one wait state before pready
  assign rd_phase = psel && penable && !pready;
  assign wr_hit = psel && penable && pready && pwrite;

  // Read multiplexer; unmapped addresses read zero and raise pslverr
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFS_CONTROL: rd_word = {24'h00_0000, flag, ack_en, sta, sto, wc, en, 1'b0, ie};
      OFS_STATUS: rd_word = {24'h00_0000, status & STATUS_CODE_MASK};
      OFS_DATA: rd_word = {24'h00_0000, data};
      OFS_IRQ_STATUS: rd_word = {30'h0000_0000, irq_sts};
      OFS_IRQ_MASK: rd_word = {30'h0000_0000, irq_mask};
      default: mapped = 1'b0;
    endcase
  end

  // Sequencer, line drivers and register file next values
  always_comb begin
    next_st = st;
    next_phase = phase;
    next_tmr = tmr;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_own_bus = own_bus;
    next_rx_mode = rx_mode;
    next_ack_bit = ack_bit;
    next_flag = flag;
    next_ack_en = ack_en;
    next_sta = sta;
    next_sto = sto;
    next_wc = wc;
    next_en = en;
    next_ie = ie;
    next_status = status;
    next_data = data;
    next_irq_sts = irq_sts;
    next_irq_mask = irq_mask;
    set_flag = 1'b0;
    lost = 1'b0;
    q_end = 1'b0;

    // Quarter timer; a slave stretching the clock freezes the rise quarter
    if (st == SEQ_IDLE || st == SEQ_HOLD) begin
      next_tmr = '0;
    end else if (phase == PH_RISE && !scl_s) begin
      next_tmr = '0;
    end else if (tmr == TMR_LAST) begin
      next_tmr = '0;
      q_end = 1'b1;
    end else begin
      next_tmr = tmr + 16'h0001;
    end

    unique case (st)
      SEQ_IDLE: begin
        if (en && sta && !flag && !busy) begin
          next_st = SEQ_START;
          next_phase = PH_SETUP;
          next_sda_oe = 1'b0;
          next_scl_oe = 1'b0;
        end
      end
      SEQ_HOLD: begin
        // Nothing moves until software writes one to the flag
        if (!flag) begin
          next_phase = PH_SETUP;
          if (status == ST_ARB_LOST) begin
            next_st = SEQ_IDLE;
            next_status = ST_NO_INFO;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
          end else if (sto) begin
            next_st = SEQ_STOP;
            next_sda_oe = 1'b1;
          end else if (sta) begin
            next_st = SEQ_START;
            next_sda_oe = 1'b0;
          end else if (status == ST_START_SENT || status == ST_RSTART_SENT) begin
            next_st = SEQ_ADDR;
            next_shreg = data;
            next_bitcnt = '0;
            next_rx_mode = data[0];
            next_sda_oe = !data[7];
          end else if (rx_mode && (status == ST_RADDR_ACK || status == ST_BYTE_ACK)) begin
            next_st = SEQ_RX;
            next_bitcnt = '0;
            next_sda_oe = 1'b0;
          end
        end
      end
      SEQ_START, SEQ_ADDR, SEQ_AACK, SEQ_RX, SEQ_ACK, SEQ_STOP: begin
        if (q_end) begin
          next_phase = phase + 2'h1;
          unique case (phase)
            PH_SETUP: next_scl_oe = 1'b0;
            PH_RISE: begin
              // Sample point, in the middle of the clock high time
              if (st == SEQ_START) begin
                next_sda_oe = 1'b1;
              end else if (st == SEQ_STOP) begin
                next_sda_oe = 1'b0;
              end else if (st == SEQ_AACK) begin
                next_ack_bit = !sda_s;
              end else if (st == SEQ_ADDR || st == SEQ_RX) begin
                next_shreg = {shreg[6:0], sda_s};
              end
              // A released data line pulled low by another master loses arbitration
              if (!sda_oe && !sda_s && (st == SEQ_ADDR || (st == SEQ_ACK && !ack_bit))) begin
                lost = 1'b1;
              end
            end
            PH_HIGH: begin
              if (st != SEQ_STOP) begin
                next_scl_oe = 1'b1;
              end
            end
            PH_FALL: begin
              unique case (st)
                SEQ_START: begin
                  next_status = own_bus ? ST_RSTART_SENT : ST_START_SENT;
                  next_own_bus = 1'b1;
                  next_st = SEQ_HOLD;
                  set_flag = 1'b1;
                end
                SEQ_ADDR, SEQ_RX: begin
                  if (bitcnt == BIT_LAST) begin
                    next_bitcnt = '0;
                    if (st == SEQ_ADDR) begin
                      next_st = SEQ_AACK;
                      next_sda_oe = 1'b0;
                    end else begin
                      next_st = SEQ_ACK;
                      next_ack_bit = ack_en;
                      next_sda_oe = ack_en;
                    end
                  end else begin
                    next_bitcnt = bitcnt + 3'h1;
                    next_sda_oe = (st == SEQ_ADDR) ? !shreg[7] : 1'b0;
                  end
                end
                SEQ_AACK: begin
                  if (rx_mode) begin
                    next_status = ack_bit ? ST_RADDR_ACK : ST_RADDR_NACK;
                  end else begin
                    next_status = ack_bit ? ST_WADDR_ACK : ST_WADDR_NACK;
                  end
                  next_st = SEQ_HOLD;
                  next_sda_oe = 1'b0;
                  set_flag = 1'b1;
                end
                SEQ_ACK: begin
                  next_data = shreg;
                  next_status = ack_bit ? ST_BYTE_ACK : ST_BYTE_NACK;
                  next_st = SEQ_HOLD;
                  next_sda_oe = 1'b0;
                  set_flag = 1'b1;
                end
                SEQ_STOP: begin
                  next_sto = 1'b0;
                  next_own_bus = 1'b0;
                  next_status = ST_NO_INFO;
                  next_st = SEQ_IDLE;
                  next_scl_oe = 1'b0;
                  next_sda_oe = 1'b0;
                end
                default: next_st = SEQ_IDLE;
              endcase
            end
          endcase
        end
      end
    endcase

    // Lost arbitration lets go of both lines, so the clock is not held here
    if (lost) begin
      next_st = SEQ_HOLD;
      next_phase = PH_SETUP;
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      next_own_bus = 1'b0;
      next_status = ST_ARB_LOST;
      set_flag = 1'b1;
    end

    // Control writes; a stop request written now overrides the self clear
    if (wr_hit && paddr == OFS_CONTROL) begin
      if (pwdata[CTL_FLAG]) begin
        next_flag = 1'b0;
      end
      next_ack_en = pwdata[CTL_ACK];
      next_sta = pwdata[CTL_STA];
      next_sto = pwdata[CTL_STO];
      next_en = pwdata[CTL_EN];
      next_ie = pwdata[CTL_IE];
    end
    // Data is only accepted while the flag is set, else a collision is flagged
    if (wr_hit && paddr == OFS_DATA) begin
      if (flag) begin
        next_data = pwdata[7:0];
        next_wc = 1'b0;
      end else begin
        next_wc = 1'b1;
      end
    end
    if (wr_hit && paddr == OFS_IRQ_STATUS) begin
      next_irq_sts = irq_sts & ~pwdata[IRQ_W-1:0];
    end
    if (wr_hit && paddr == OFS_IRQ_MASK) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end

    // Hardware set wins over a clear in the same cycle
    if (set_flag) begin
      next_flag = 1'b1;
      next_irq_sts[IRQ_STEP] = 1'b1;
    end
    if (lost) begin
      next_irq_sts[IRQ_LOST] = 1'b1;
    end

    // A disabled interface drops the bus and forgets the transfer
    if (!en) begin
      next_st = SEQ_IDLE;
      next_phase = PH_SETUP;
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      next_own_bus = 1'b0;
      next_status = ST_NO_INFO;
    end
  end

  // APB answer and interrupt line, all from flops
  always_comb begin
    next_pready = rd_phase;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (rd_phase) begin
      next_prdata = rd_word;
      next_pslverr = !mapped;
    end
    next_irq = ie && (|(irq_sts & irq_mask));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SEQ_IDLE;
      phase <= PH_SETUP;
      tmr <= '0;
      bitcnt <= '0;
      shreg <= DATA_RESET;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      own_bus <= 1'b0;
      rx_mode <= 1'b0;
      ack_bit <= 1'b0;
      flag <= 1'b0;
      ack_en <= 1'b0;
      sta <= 1'b0;
      sto <= 1'b0;
      wc <= 1'b0;
      en <= 1'b0;
      ie <= 1'b0;
      status <= ST_NO_INFO;
      data <= DATA_RESET;
      irq_sts <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      st <= next_st;
      phase <= next_phase;
      tmr <= next_tmr;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_out <= 1'b0; // Open drain: only ever pulls low
      sda_out <= 1'b0;
      own_bus <= next_own_bus;
      rx_mode <= next_rx_mode;
      ack_bit <= next_ack_bit;
      flag <= next_flag;
      ack_en <= next_ack_en;
      sta <= next_sta;
      sto <= next_sto;
      wc <= next_wc;
      en <= next_en;
      ie <= next_ie;
      status <= next_status;
      data <= next_data;
      irq_sts <= next_irq_sts;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

endmodule

// File: sim/two_wire_master_receiver_checker.sv
// Port-level assertions for the two-wire master receiver
`timescale 1ns/1ps
module two_wire_master_receiver_checker
  import two_wire_pkg::*;
#(
  parameter int quarter_cycles = QUARTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic ctl_wr, mapped;
  logic [7:0] c;
  logic [15:0] low_cnt, next_low_cnt;
  logic [3:0] wr_age, next_wr_age;
  // Control write completing this cycle, and its byte
  assign ctl_wr = psel && penable && pready && pwrite && paddr == OFS_CONTROL;
  assign mapped = paddr inside {OFS_CONTROL, OFS_STATUS, OFS_DATA, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  assign c = pwdata[7:0];
  // Clock-low run and age of the last control write; both saturate so they never wrap
  always_comb begin
    next_low_cnt = scl_oe ? low_cnt + 16'(low_cnt != 16'hFFFF) : 16'h0000;
    next_wr_age = ctl_wr ? 4'h0 : wr_age + 4'(wr_age != 4'hF);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 16'h0000;
      wr_age <= 4'hF;
    end else begin
      low_cnt <= next_low_cnt;
      wr_age <= next_wr_age;
    end
  end
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready stayed high for more than one cycle");
  AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase did not take exactly one wait state");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside a held access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  AST_ERR_ZERO_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned nonzero data");
  AST_OPEN_DRAIN: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line output driven high");
  AST_START_GEN: assert property (ctl_wr && c[CTL_FLAG] && c[CTL_STA] && !c[CTL_STO] && c[CTL_EN]
    && !scl_oe && !sda_oe |-> ##[1:1000] ($rose(sda_oe) && !scl_oe))
    else $error("no START after start request on a free bus");
  AST_STOP_GEN: assert property (ctl_wr && c[CTL_FLAG] && c[CTL_STO] && c[CTL_EN]
    |-> ##[1:1000] ($fell(sda_oe) && !scl_oe))
    else $error("no STOP after stop request");
  AST_HOLD_LOW: assert property (low_cnt > 16'(2 * quarter_cycles + 2) && wr_age > 4'h8 |-> scl_oe)
    else $error("clock released while waiting for software");
  cover property (ctl_wr && c[CTL_STA] && c[CTL_STO]);
  cover property (pslverr);
  cover property ($fell(sda_oe) && !scl_oe);
endmodule

bind two_wire_master_receiver two_wire_master_receiver_checker #(
  .quarter_cycles(quarter_cycles)
) two_wire_master_receiver_checker_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
);

// File: sim/slave_tx_model.sv
// Behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
module slave_tx_model #(
  parameter logic [6:0] own_addr = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  output logic pull,
  output logic mack
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hA5;
  logic act = 1'b0;
  logic dat = 1'b0;
  logic rd = 1'b0;
  int cnt = 0;
  initial begin
    pull = 1'b0;
    mack = 1'b1;
  end
  // Data edge with clock high: START opens an address phase, STOP frees the bus
  always @(sda) begin
    if (scl === 1'b1) begin
      act = !sda;
      dat = 1'b0;
      cnt = 0;
      pull = 1'b0;
    end
  end
  // Shift in each bit on the rising clock
  always @(posedge scl) begin
    if (act) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
    end
  end
  // Change the data line only while the clock is low, so no false START or STOP
  always @(negedge scl) begin
    if (act && !dat && cnt == 8) begin
      pull = (sh[7:1] == own_addr);
      act = pull;
      rd = sh[0];
    end else if (act && !dat && cnt == 9) begin
      dat = rd;
      act = rd;
      cnt = 0;
      pull = rd && !tx[7];
    end else if (act && dat && cnt < 8) begin
      pull = !tx[7-cnt];
    end else if (act && dat && cnt == 8) begin
      pull = 1'b0;
    end else if (act && dat && cnt == 9) begin
      mack = sh[0];
      act = !sh[0];
      tx = tx + 8'h01;
      cnt = 0;
      pull = !sh[0] && !tx[7];
    end
  end
endmodule

// File: sim/tb.sv
// Testbench: APB sequences driving the master receiver against a slave model
`timescale 1ns/1ps
module tb;
  import two_wire_pkg::*;
  localparam int qc = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic scl_oe, sda_oe, slv_pull, mack, arb_pull;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail, checks;
  // Open-drain wires with pull-ups
  wire logic scl = !scl_oe;
  // Bench pull stands in for a second master that wins arbitration
  wire logic sda = !(sda_oe || slv_pull || arb_pull);
  two_wire_master_receiver #(.quarter_cycles(qc)) two_wire_master_receiver_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe)
  );
  slave_tx_model slave_tx_model_i (.scl(scl), .sda(sda), .pull(slv_pull), .mack(mack));
  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h00_0000, exp});
  endtask
  // Poll the control register until a bit reaches a value, bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 100);
    if (rd[b] !== v) n_fail++;
  endtask
  // Write control, wait for the step-done flag, check the status code
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    apb(1'b1, OFS_CONTROL, {24'h00_0000, c});
    poll(CTL_FLAG, 1'b1);
    rdchk(OFS_STATUS, st);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Watchdog sized well above the expected run of about a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    n_fail = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = OFS_CONTROL;
    pwdata = 32'h0000_0000;
    arb_pull = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_CONTROL, 8'h00);
    rdchk(OFS_STATUS, 8'hF8);
    rdchk(OFS_DATA, 8'h00);
    rdchk(OFS_IRQ_STATUS, 8'h00);
    rdchk(OFS_IRQ_MASK, 8'h00);
    rdchk(12'h014, 8'h00);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    step(8'hA5, 8'h08);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    rdchk(OFS_IRQ_STATUS, 8'h00);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, OFS_DATA, 32'h0000_0055);
    step(8'hC5, 8'h40);
    chk(32'(irq), 32'h0000_0000);
    rdchk(OFS_IRQ_STATUS, 8'h01);
    step(8'hC5, 8'h50);
    rdchk(OFS_DATA, 8'hA5);
    chk(32'(mack), 32'h0000_0000);
    step(8'h85, 8'h58);
    rdchk(OFS_DATA, 8'hA6);
    chk(32'(mack), 32'h0000_0001);
    step(8'hA5, 8'h10);
    apb(1'b1, OFS_DATA, 32'h0000_0057);
    step(8'h85, 8'h48);
    step(8'hA5, 8'h10);
    apb(1'b1, OFS_DATA, 32'h0000_0057);
    step(8'h85, 8'h48);
    step(8'hB5, 8'h08);
    // Data line held low through the first released address bit loses arbitration
    apb(1'b1, OFS_DATA, 32'h0000_00D5);
    arb_pull <= 1'b1;
    step(8'h85, 8'h38);
    rdchk(OFS_IRQ_STATUS, 8'h03);
    chk(32'({scl_oe, sda_oe}), 32'h0000_0000);
    // Letting go with the clock high is a STOP, so the bus becomes free again
    arb_pull <= 1'b0;
    step(8'hA5, 8'h08);
    apb(1'b1, OFS_DATA, 32'h0000_0054);
    step(8'h85, 8'h18);
    apb(1'b1, OFS_CONTROL, 32'h0000_0095);
    poll(CTL_STO, 1'b0);
    rdchk(OFS_STATUS, 8'hF8);
    rdchk(OFS_CONTROL, 8'h05);
    chk(32'({scl_oe, sda_oe}), 32'h0000_0000);
    apb(1'b1, OFS_DATA, 32'h0000_0077);
    rdchk(OFS_CONTROL, 8'h0D);
    end_of_test();
  end
endmodule
